// [core/gst_timer.v]
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "gst_regs.vh"

// Overview of operation
// [R1] count increments to FFFFh then wraps to 0000h
// [R2] wrap sets sticky overflow flag; irq needs overflow, peripheral, global enables
// [R3] count reads stay valid with an asynchronous external clock
// [R4] software should stop the counter before writing count bytes
// [R5] gate from gate pin or comparator two, chosen by source select, if enabled
// [R6] polarity bit one counts on high gate, zero on low gate
// [R7] gate enable ignored when off; zero counts freely, one obeys gate
// [R8] prescale field gives 1:1, 1:2, 1:4, 1:8
// [R9] crystal enable only acts when internal osc without clock output is system
// [R10] sync bypass bit passes external clock unsynchronised; ignored for internal clock; the code still synchronises it
// [R11] source bit one counts external rising edges, zero counts Fosc/4
// [R12] counter_on zero stops counting and keeps count
// [R13] count bytes keep value across resets; high byte is upper half
// [R14] in sleep only asynchronous external mode keeps counting
// [R15] overflow in sleep with enables wakes device; vector 0004h if global
// [R16] capture copies 16-bit count on capture event
// [R17] compare event when compare pair equals count
// [R18] special event trigger clears count without setting overflow flag
// [R19] count write wins over a simultaneous special event clear
// [R20] software should use synchronous mode with the special event trigger
// [R21] comparator output can be synchronised to the counter clock
// [R22] software should clear count and flag before enabling interrupt
// [R23] count write also clears the hidden prescale counter
// [R24] external mode needs a falling edge before first counted rising edge
module gst_timer #(
    parameter PRESCALE_WIDTH = 3
) (
    input wire clk_sys_in,
    input wire rst_in,
    input wire [5:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    input wire external_clock_pin_in,
    input wire gate_pin_in,
    input wire comparator_two_output_in,
    input wire capture_event_in,
    input wire sleep_in,
    input wire internal_oscillator_no_clock_output_in,
    input wire crystal_clock_in,
    output reg irq_out,
    output reg wake_out,
    output reg [15:0] irq_vector_out,
    output reg compare_event_out,
    output reg crystal_osc_active_out
);
    // register map, one byte per word, low byte of the bus only:
    //   0x00 timer control: on, source, sync bypass, crystal, prescale, gate
    //   0x04 link control: comparator sync and gate source select
    //   0x08 count low byte, 0x0C count high byte
    //   0x10 overflow flag, write zero to clear it
    //   0x14 enables: overflow, peripheral, global
    //   0x18 and 0x1C compare pair, low then high
    //   0x20 capture/compare control: capture, compare, special trigger
    //   0x24 and 0x28 capture pair, read only
    // every other word reads as zero and ignores writes
    //
    // the two count bytes are read independently; software that needs
    // a coherent 16-bit value should stop the counter first or read
    // high, low, high and retry on a carry between the reads
    //
    // the count itself has no reset so that it survives a soft reset;
    // software must load it before it means anything

    // control and state registers
    reg [7:0] timer_control;
    reg [7:0] comparator_timer_link_control;
    reg [15:0] count;
    reg overflow_flag;
    reg [2:0] irq_enable;
    reg [15:0] compare_pair;
    reg [2:0] cc_control;
    reg [15:0] capture_pair;
    reg [PRESCALE_WIDTH-1:0] prescale_count;
    reg [1:0] quarter;
    reg ack;
    // synchronisers: first stage read only by second
    reg ext_s1, ext_s2, ext_prev;
    reg xtal_s1, xtal_s2, xtal_prev;
    reg gpin_s1, gpin_s2;
    reg cmp_s1, cmp_s2;
    reg cap_s1, cap_s2, cap_prev;
    reg slp_s1, slp_s2;
    reg osc_s1, osc_s2;
    reg cmp_at_tick;
    reg armed;
    reg last_on;

    wire ctl_on = timer_control[`GST_CTL_ON];
    wire ctl_cs = timer_control[`GST_CTL_CS];
    wire ctl_async = timer_control[`GST_CTL_SYNCB];
    wire [1:0] ctl_ps = timer_control[`GST_CTL_PS_LO+1:`GST_CTL_PS_LO];

    // clock source selection
    // the external pin and the crystal are both sampled by the system
    // clock, so their highest usable rate is below half of it;
    // faster sources would alias and lose edges
    // the crystal replaces the pin only when the clock setup allows it,
    // so a stray enable bit in any other setup has no effect
    //
    // the "async" path still goes through the synchroniser so reads are always coherent;
    // it differs only in keeping running during sleep
    wire xosc_used = timer_control[`GST_CTL_XOSC] & osc_s2; // [R9]
    wire ext_level = xosc_used ? xtal_s2 : ext_s2;
    wire ext_prev_level = xosc_used ? xtal_prev : ext_prev;
    wire ext_rise = ext_level & ~ext_prev_level; // [R11]
    wire ext_fall = ~ext_level & ext_prev_level;
    wire int_tick = (quarter == 2'h3); // [R11] Fosc/4
    wire async_ext = ctl_cs & ctl_async; // [R10]
    wire run_sleep = ~slp_s2 | async_ext; // [R14]
    wire src_tick = ctl_cs ? (ext_rise & armed) : int_tick; // [R24]

    // gate path
    // the gate source is picked first, then its polarity is applied,
    // so the polarity bit means the same thing for pin and comparator
    // with gating off the counter runs whenever it is switched on and not held by sleep
    // resampling the comparator at counter ticks keeps the gate steady
    // between two source ticks, so a comparator edge cannot split one
    //
    // comparator path optionally resampled at counter clock ticks
    wire cmp_level = comparator_timer_link_control[`GST_LNK_CSYNC] ? cmp_at_tick : cmp_s2; // [R21]
    wire gate_raw = comparator_timer_link_control[`GST_LNK_GSS] ? gpin_s2 : cmp_level; // [R5]
    wire gate_act = timer_control[`GST_CTL_GINV] ? gate_raw : ~gate_raw; // [R6]
    wire gate_ok = ~timer_control[`GST_CTL_GE] | gate_act; // [R7]
    wire enabled = ctl_on & gate_ok & run_sleep; // [R12]

    // prescaler
    // the hidden prescale counter only moves on enabled source ticks,
    // so a stopped or gated counter also freezes the prescaler phase
    // it is cleared by every count write, so a freshly loaded value
    // always sees a full prescale period before its first increment
    //
    // prescale terminal count per select
    reg [PRESCALE_WIDTH-1:0] ps_last;
    always @* begin
        case (ctl_ps) // [R8]
            2'h0: ps_last = 3'h0;
            2'h1: ps_last = 3'h1;
            2'h2: ps_last = 3'h3;
            default: ps_last = 3'h7;
        endcase
    end
    wire do_tick = enabled & src_tick;
    wire inc = do_tick & (prescale_count == ps_last);
    wire wrap = inc & (count == 16'hFFFF); // [R1]

    // bus decode
    // a write lands at the edge where waitrequest is low, the same edge
    // at which the master sees it accepted; a read is sampled one edge
    // earlier so its data already stands when waitrequest drops
    // only byte lane zero carries register data
    wire wr = avs_write_in & ack;
    wire rd = avs_read_in & ~ack;
    wire be0 = avs_byteenable_in[0];
    wire wr_cntl = wr & be0 & (avs_address_in == `GST_ADDR_CNTL);
    wire wr_cnth = wr & be0 & (avs_address_in == `GST_ADDR_CNTH);
    wire wr_flag = wr & be0 & (avs_address_in == `GST_ADDR_FLAG);
    wire spec_trig = cc_control[`GST_CC_SPEC] & (count == compare_pair) & inc;
    wire cap_rise = cap_s2 & ~cap_prev;

    // synchronisers and free-running quarter counter
    // every asynchronous input passes two flops before any logic reads
    // it; the third flop of the edge detectors is read only as history
    // the quarter counter makes the internal instruction tick; it runs
    // freely so that switching the counter on does not restart its phase
    always @(posedge clk_sys_in) begin
        ext_s1 <= external_clock_pin_in;
        ext_s2 <= ext_s1;
        ext_prev <= ext_s2;
        xtal_s1 <= crystal_clock_in;
        xtal_s2 <= xtal_s1;
        xtal_prev <= xtal_s2;
        gpin_s1 <= gate_pin_in;
        gpin_s2 <= gpin_s1;
        cmp_s1 <= comparator_two_output_in;
        cmp_s2 <= cmp_s1;
        cap_s1 <= capture_event_in;
        cap_s2 <= cap_s1;
        cap_prev <= cap_s2;
        slp_s1 <= sleep_in;
        slp_s2 <= slp_s1;
        osc_s1 <= internal_oscillator_no_clock_output_in;
        osc_s2 <= osc_s1;
        if (rst_in) begin
            quarter <= 2'h0;
            cmp_at_tick <= 1'b0;
        end else begin
            quarter <= quarter + 2'h1;
            if (src_tick)
                cmp_at_tick <= cmp_s2; // [R21]
        end
    end

    // count, prescaler and falling-edge arming; count is not reset
    // priority: software write, then special trigger clear, then increment
    // a write to one byte leaves the other byte untouched
    // arming drops on any count write and while the counter is off, so
    // a pin left high across a restart cannot fake a rising edge
    always @(posedge clk_sys_in) begin
        if (wr_cntl) begin
            count[7:0] <= avs_writedata_in[7:0]; // [R13] [R19]
        end else if (wr_cnth) begin
            count[15:8] <= avs_writedata_in[7:0]; // [R19]
        end else if (spec_trig) begin
            count <= 16'h0000; // [R18]
        end else if (inc) begin
            count <= count + 16'h0001; // [R1]
        end
        if (rst_in) begin
            prescale_count <= {PRESCALE_WIDTH{1'b0}};
            armed <= 1'b0;
            last_on <= 1'b0;
        end else begin
            last_on <= ctl_on;
            if (wr_cntl | wr_cnth)
                prescale_count <= {PRESCALE_WIDTH{1'b0}}; // [R23]
            else if (inc)
                prescale_count <= {PRESCALE_WIDTH{1'b0}};
            else if (do_tick)
                prescale_count <= prescale_count + 3'h1;
            if (wr_cntl | wr_cnth | ~ctl_on)
                armed <= 1'b0; // [R24]
            else if (ext_fall)
                armed <= 1'b1;
        end
    end

    // overflow flag: hardware set beats software clear
    // losing a clear is harmless, losing a wrap would hide an event
    always @(posedge clk_sys_in) begin
        if (rst_in)
            overflow_flag <= 1'b0;
        else if (wrap)
            overflow_flag <= 1'b1; // [R2]
        else if (wr_flag & ~avs_writedata_in[0])
            overflow_flag <= 1'b0;
    end

    // register writes
    // the link register keeps only its two defined bits, the rest read 0
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            timer_control <= `GST_CTRL_RST;
            comparator_timer_link_control <= `GST_LINK_RST;
            irq_enable <= 3'h0;
            compare_pair <= 16'h0000;
            cc_control <= 3'h0;
        end else if (wr & be0) begin
            if (avs_address_in == `GST_ADDR_CTRL)
                timer_control <= avs_writedata_in[7:0];
            else if (avs_address_in == `GST_ADDR_LINK)
                comparator_timer_link_control <= {6'h00, avs_writedata_in[1:0]};
            else if (avs_address_in == `GST_ADDR_IEN)
                irq_enable <= avs_writedata_in[2:0];
            else if (avs_address_in == `GST_ADDR_CMPL)
                compare_pair[7:0] <= avs_writedata_in[7:0];
            else if (avs_address_in == `GST_ADDR_CMPH)
                compare_pair[15:8] <= avs_writedata_in[7:0];
            else if (avs_address_in == `GST_ADDR_CCCTL)
                cc_control <= avs_writedata_in[2:0];
        end
    end

    // capture pair
    // the capture event is synchronised, so the copied count is the one
    // present two to three clocks after the event reached the pin
    always @(posedge clk_sys_in) begin
        if (rst_in)
            capture_pair <= 16'h0000;
        else if (cc_control[`GST_CC_CAPEN] & cap_rise)
            capture_pair <= count; // [R16]
    end

    // bus answer: one wait cycle, then ack; unmapped reads return zero
    // ack blocks a second answer to a request that is still held, so a
    // master holding read or write for an extra cycle is seen twice only
    // after waitrequest has gone high again
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            ack <= 1'b0;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            ack <= (avs_read_in | avs_write_in) & ~ack;
            avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & ~ack);
            if (rd) begin
                if (avs_address_in == `GST_ADDR_CTRL)
                    avs_readdata_out <= {24'h000000, timer_control};
                else if (avs_address_in == `GST_ADDR_LINK)
                    avs_readdata_out <= {24'h000000, comparator_timer_link_control};
                else if (avs_address_in == `GST_ADDR_CNTL)
                    avs_readdata_out <= {24'h000000, count[7:0]}; // [R3]
                else if (avs_address_in == `GST_ADDR_CNTH)
                    avs_readdata_out <= {24'h000000, count[15:8]}; // [R3]
                else if (avs_address_in == `GST_ADDR_FLAG)
                    avs_readdata_out <= {31'h00000000, overflow_flag};
                else if (avs_address_in == `GST_ADDR_IEN)
                    avs_readdata_out <= {29'h00000000, irq_enable};
                else if (avs_address_in == `GST_ADDR_CMPL)
                    avs_readdata_out <= {24'h000000, compare_pair[7:0]};
                else if (avs_address_in == `GST_ADDR_CMPH)
                    avs_readdata_out <= {24'h000000, compare_pair[15:8]};
                else if (avs_address_in == `GST_ADDR_CCCTL)
                    avs_readdata_out <= {29'h00000000, cc_control};
                else if (avs_address_in == `GST_ADDR_CAPL)
                    avs_readdata_out <= {24'h000000, capture_pair[7:0]};
                else if (avs_address_in == `GST_ADDR_CAPH)
                    avs_readdata_out <= {24'h000000, capture_pair[15:8]};
                else
                    avs_readdata_out <= 32'h0000_0000;
            end
        end
    end

    // interrupt, wake and compare outputs
    // all outputs are registered, so each follows its inputs by one clock
    // wake ignores the global enable: the device wakes and resumes, and
    // only then does the global enable decide whether to vector
    // the compare event is a level that stands while count and pair match
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
            wake_out <= 1'b0;
            irq_vector_out <= 16'h0000;
            compare_event_out <= 1'b0;
            crystal_osc_active_out <= 1'b0;
        end else begin
            irq_out <= overflow_flag & (&irq_enable); // [R2]
            wake_out <= slp_s2 & overflow_flag & irq_enable[`GST_IEN_OVF]
                        & irq_enable[`GST_IEN_PER]; // [R15]
            irq_vector_out <= (overflow_flag & (&irq_enable)) ? `GST_VECTOR : 16'h0000; // [R15]
            compare_event_out <= cc_control[`GST_CC_CMPEN] & (count == compare_pair); // [R17]
            crystal_osc_active_out <= xosc_used; // [R9]
        end
    end
endmodule

// [core/gst_regs.vh]
`ifndef GST_REGS_VH
`define GST_REGS_VH
// register byte addresses (word aligned)
`define GST_ADDR_CTRL 6'h00
`define GST_ADDR_LINK 6'h04
`define GST_ADDR_CNTL 6'h08
`define GST_ADDR_CNTH 6'h0C
`define GST_ADDR_FLAG 6'h10
`define GST_ADDR_IEN 6'h14
`define GST_ADDR_CMPL 6'h18
`define GST_ADDR_CMPH 6'h1C
`define GST_ADDR_CCCTL 6'h20
`define GST_ADDR_CAPL 6'h24
`define GST_ADDR_CAPH 6'h28
// timer_control fields
`define GST_CTL_ON 0
`define GST_CTL_CS 1
`define GST_CTL_SYNCB 2
`define GST_CTL_XOSC 3
`define GST_CTL_PS_LO 4
`define GST_CTL_GE 6
`define GST_CTL_GINV 7
// comparator_timer_link_control fields
`define GST_LNK_CSYNC 0
`define GST_LNK_GSS 1
// interrupt enable register fields
`define GST_IEN_OVF 0
`define GST_IEN_PER 1
`define GST_IEN_GLB 2
// capture/compare control fields
`define GST_CC_CAPEN 0
`define GST_CC_CMPEN 1
`define GST_CC_SPEC 2
// reset values and interrupt vector
`define GST_CTRL_RST 8'h00
`define GST_LINK_RST 8'h02
`define GST_VECTOR 16'h0004
`endif

// [testbench/gst_assertions.sv]
`timescale 1ns/1ps
module gst_assertions (
    input wire clk_sys_in,
    input wire rst_in,
    input wire [5:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    input wire [31:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    input wire irq_out,
    input wire wake_out,
    input wire [15:0] irq_vector_out
);
    reg [7:0] ctl_sh;
    reg [2:0] ien_sh;
    wire req = avs_read_in || avs_write_in;
    wire wr_tk = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
    wire rd_ack = avs_read_in && !avs_waitrequest_out;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    // shadows load at the accepting edge of a write, where the design takes it
    always @(posedge clk_sys_in) begin
        if (rst_in) begin
            ctl_sh <= 8'h00;
            ien_sh <= 3'h0;
        end else if (wr_tk) begin
            if (avs_address_in == 6'h00)
                ctl_sh <= avs_writedata_in[7:0];
            if (avs_address_in == 6'h14)
                ien_sh <= avs_writedata_in[2:0];
        end
    end
    property p_ack_next; req && avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
    a_ack_next: assert property (p_ack_next) else $error("late ack");
    property p_ack_one; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    property p_rd_hi; rd_ack |-> avs_readdata_out[31:8] == 24'h000000; endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
    property p_ctl_rb; rd_ack && avs_address_in == 6'h00 |-> avs_readdata_out[7:0] == ctl_sh;
    endproperty
    a_ctl_rb: assert property (p_ctl_rb) else $error("control readback");
    property p_hole; rd_ack && avs_address_in > 6'h28 |-> avs_readdata_out == 32'h0; endproperty
    a_hole: assert property (p_hole) else $error("hole not zero");
    property p_vec; irq_out |-> irq_vector_out == 16'h0004; endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_irq_en; irq_out |-> $past(ien_sh) == 3'h7; endproperty
    a_irq_en: assert property (p_irq_en) else $error("irq without enables");
    property p_wake_en; wake_out |-> $past(ien_sh[1:0]) == 2'h3; endproperty
    a_wake_en: assert property (p_wake_en) else $error("wake without enables");
    c_irq: cover property (irq_out);
    c_wake: cover property (wake_out);
    c_cap: cover property (rd_ack && avs_address_in == 6'h24);
endmodule

// [testbench/gst_partner.sv]
`timescale 1ns/1ps
module gst_ext_source (
    input wire clk_sys_in,
    input wire go_in,
    input wire [7:0] pulses_in,
    output reg clock_out,
    output reg busy_out
);
    integer left = 0;
    integer ph = 0;
    initial clock_out = 1'h0;
    initial busy_out = 1'h0;
    // idles low between bursts, so each burst opens with a rising edge
    always @(posedge clk_sys_in) begin
        ph <= (ph + 1) % 4;
        if (go_in && !busy_out) begin
            left <= 2 * pulses_in;
            busy_out <= 1'h1;
        end else if (busy_out && ph == 3) begin
            clock_out <= !clock_out;
            left <= left - 1;
            busy_out <= left > 1;
        end
    end
endmodule

// [testbench/tb.sv]
`timescale 1ns/1ps
module tb;
    reg clk_sys_in, rst_in, avs_read_in, avs_write_in, go, saw_cmp;
    reg gate_pin_in, comparator_two_output_in, capture_event_in;
    reg sleep_in, internal_oscillator_no_clock_output_in, crystal_clock_in;
    reg [5:0] avs_address_in;
    reg [31:0] avs_writedata_in, rdata;
    reg [3:0] avs_byteenable_in;
    reg [7:0] npulse;
    wire [31:0] avs_readdata_out;
    wire [15:0] irq_vector_out;
    wire avs_waitrequest_out, irq_out, wake_out, compare_event_out;
    wire crystal_osc_active_out, external_clock_pin_in, src_busy;
    integer failures, checked, cyc, i, w, e, cv;
    gst_timer #(.PRESCALE_WIDTH(3)) gst_timer_inst (.clk_sys_in, .rst_in, .avs_address_in,
        .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
        .avs_waitrequest_out, .external_clock_pin_in, .gate_pin_in, .comparator_two_output_in,
        .capture_event_in, .sleep_in, .internal_oscillator_no_clock_output_in, .crystal_clock_in, .irq_out,
        .wake_out, .irq_vector_out, .compare_event_out, .crystal_osc_active_out);
    gst_ext_source gst_ext_source_inst (.clk_sys_in, .go_in(go), .pulses_in(npulse),
        .clock_out(external_clock_pin_in), .busy_out(src_busy));
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("unexpected at %0t: got %h want %h", $time, seen, exp);
            end
        end
    endtask
    // holds the request until the edge at which waitrequest is low; spare edge after release
    task bus(input rd, input [5:0] a, input [7:0] d);
        begin
            avs_address_in <= a;
            avs_writedata_in <= {24'h000000, d};
            avs_read_in <= rd;
            avs_write_in <= !rd;
            @(negedge clk_sys_in);
            while (avs_waitrequest_out !== 1'h0) @(negedge clk_sys_in);
            @(posedge clk_sys_in);
            rdata = avs_readdata_out;
            avs_read_in <= 1'h0;
            avs_write_in <= 1'h0;
            @(posedge clk_sys_in);
        end
    endtask
    // counter is stopped before its bytes are written, except for the load in sleep, where it is only frozen
    task setc(input [15:0] v);
        begin
            bus(1'h0, 6'h08, v[7:0]);
            bus(1'h0, 6'h0C, v[15:8]);
        end
    endtask
    task getc;
        begin
            bus(1'h1, 6'h08, 8'h00);
            cv = rdata[7:0];
            bus(1'h1, 6'h0C, 8'h00);
            cv = cv + 256 * rdata[7:0];
        end
    endtask
    task pulses(input [7:0] n);
        begin
            npulse <= n;
            go <= 1'h1;
            @(posedge clk_sys_in);
            go <= 1'h0;
            @(posedge clk_sys_in);
            while (src_busy === 1'h1) @(posedge clk_sys_in);
            repeat (8) @(posedge clk_sys_in);
        end
    endtask
    // one tick of slack: sampling of the start and stop edges is not cycle exact
    function [31:0] near(input integer v, input integer x);
        near = (v >= x - 1) && (v <= x + 1);
    endfunction
    task end_of_test;
        begin
            if (failures == 0 && checked > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        clk_sys_in = 1'h0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) if (compare_event_out === 1'h1) saw_cmp <= 1'h1;
    // a hang is cut short well past the expected run length
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            end_of_test;
        end
    end
    initial begin
        {avs_read_in, avs_write_in, go, saw_cmp, gate_pin_in, comparator_two_output_in} = 6'h00;
        {capture_event_in, sleep_in, internal_oscillator_no_clock_output_in, crystal_clock_in} = 4'h0;
        avs_address_in = 6'h00;
        avs_writedata_in = 32'h0;
        avs_byteenable_in = 4'hF;
        npulse = 8'h00;
        {failures, checked, cyc} = 96'h0;
        rst_in = 1'h1;
        w = $urandom(32'h29637420);
        repeat (12) @(posedge clk_sys_in);
        rst_in <= 1'h0;
        @(posedge clk_sys_in);
        bus(1'h1, 6'h04, 8'h00);
        chk(rdata, 32'h2);
        bus(1'h1, 6'h2C, 8'h00);
        chk(rdata, 32'h0);
        setc(16'hA53C);
        getc;
        chk(cv, 32'hA53C);
        e = $urandom;
        setc(e[15:0]);
        getc;
        chk(cv, e & 32'hFFFF);
        for (i = 0; i < 4; i = i + 1) begin
            w = 40 + $urandom % 80;
            setc(16'h0000);
            bus(1'h0, 6'h00, {2'h0, i[1:0], 4'h1});
            repeat (w) @(posedge clk_sys_in);
            bus(1'h0, 6'h00, 8'h00);
            getc;
            chk(near(cv, (w + 3) / (4 << i)), 32'h1);
        end
        e = cv;
        repeat (20) @(posedge clk_sys_in);
        getc;
        chk(cv, e);
        // every polarity and source, with the unselected source at the opposite level
        for (i = 0; i < 8; i = i + 1) begin
            bus(1'h0, 6'h04, {6'h00, i[1], i[0]});
            gate_pin_in <= i[1] ? (i[2] == i[0]) : (i[2] != i[0]);
            comparator_two_output_in <= i[1] ? (i[2] != i[0]) : (i[2] == i[0]);
            setc(16'h0000);
            bus(1'h0, 6'h00, {i[0], 7'h41});
            repeat (60) @(posedge clk_sys_in);
            bus(1'h0, 6'h00, 8'h00);
            getc;
            chk(near(cv, i[2] ? 15 : 0), 32'h1);
        end
        setc(16'hFFFE);
        bus(1'h0, 6'h00, 8'h01);
        repeat (12) @(posedge clk_sys_in);
        bus(1'h0, 6'h00, 8'h00);
        getc;
        chk(near(cv, 1), 32'h1);
        bus(1'h1, 6'h10, 8'h00);
        chk(rdata, 32'h1);
        bus(1'h0, 6'h14, 8'h07);
        repeat (3) @(posedge clk_sys_in);
        chk({31'h0, irq_out}, 32'h1);
        chk({16'h0, irq_vector_out}, 32'h4);
        bus(1'h0, 6'h10, 8'h00); // flag cleared before enables are relied on again
        repeat (3) @(posedge clk_sys_in);
        chk({31'h0, irq_out}, 32'h0);
        setc(16'h0000);
        bus(1'h0, 6'h18, 8'h0A);
        bus(1'h0, 6'h1C, 8'h00);
        bus(1'h0, 6'h20, 8'h06);
        bus(1'h0, 6'h00, 8'h01);
        repeat (200) @(posedge clk_sys_in);
        bus(1'h0, 6'h00, 8'h00);
        getc;
        chk({31'h0, cv <= 10}, 32'h1);
        chk({31'h0, saw_cmp}, 32'h1);
        bus(1'h1, 6'h10, 8'h00);
        chk(rdata, 32'h0);
        setc(16'h1234);
        bus(1'h0, 6'h20, 8'h01);
        capture_event_in <= 1'h1;
        repeat (6) @(posedge clk_sys_in);
        bus(1'h1, 6'h24, 8'h00);
        chk(rdata, 32'h34);
        bus(1'h1, 6'h28, 8'h00);
        chk(rdata, 32'h12);
        bus(1'h0, 6'h00, 8'h08);
        repeat (8) @(posedge clk_sys_in);
        chk({31'h0, crystal_osc_active_out}, 32'h0);
        internal_oscillator_no_clock_output_in <= 1'h1;
        repeat (8) @(posedge clk_sys_in);
        chk({31'h0, crystal_osc_active_out}, 32'h1);
        setc(16'h0000);
        bus(1'h0, 6'h00, 8'h03);
        pulses(8'h05);
        getc;
        chk(cv, 32'h4);
        sleep_in <= 1'h1;
        setc(16'hFFFE);
        pulses(8'h03);
        getc;
        chk(cv, 32'hFFFE);
        bus(1'h0, 6'h00, 8'h07);
        pulses(8'h03);
        getc;
        chk(near(cv, 1), 32'h1);
        chk({31'h0, wake_out}, 32'h1);
        end_of_test;
    end
endmodule
bind gst_timer gst_assertions gst_assertions_inst (.clk_sys_in, .rst_in, .avs_address_in,
    .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
    .avs_waitrequest_out, .irq_out, .wake_out, .irq_vector_out);
